/* design/rlm_pkg.sv */
// package for the remote/local mode controller: offsets, fields, types
// assumes an axi4-lite master with 32-bit data and one aligned word per reg
package rlm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TRIG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SBYTE = 8'h0C;
  // ctrl: write-one command pulses
  localparam int CTL_GTL = 0;
  localparam int CTL_DCL = 1;
  localparam int CTL_LLO = 2;
  localparam int CTL_GET = 3;
  localparam int CTL_ABORT = 4;
  localparam int CTL_IFC = 5;
  // status fields
  localparam int ST_REMOTE = 0;
  localparam int ST_LOCKOUT = 1;
  localparam int ST_LISTEN = 2;
  localparam int ST_TALK = 3;
  localparam int ST_MEAS_VALID = 4;
  localparam int ST_MEAS_BUSY = 5;
  localparam int ST_ARMED = 6;
  // trig fields
  localparam int TR_SETTLE = 0;
  localparam int TR_REPEAT = 1;
  // status byte service request bit
  localparam int SB_RQS = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] TRIG_DEFAULT = 2'h3;
  localparam int MEAS_NS = 1000;
  localparam int CLK_NS = 50;
  localparam int MEAS_CYC = (MEAS_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    RLM_LOCAL = 2'b00,
    RLM_REMOTE = 2'b01,
    RLM_REMOTE_LLO = 2'b10
  } rlm_mode_t;

  typedef struct packed {
    logic complete_settle_option;
    logic repeat_trigger_mode; // 0 means single_trigger_mode
  } rlm_trig_t;

  typedef struct packed {
    rlm_mode_t mode;
    logic lockout;
    rlm_trig_t trig;
    rlm_trig_t remote_trig;
    logic remote_trig_set;
    logic meas_valid;
    logic meas_busy;
    logic [7:0] meas_cnt;
    logic armed;
    logic srq;
    logic [6:0] sbyte;
    logic clear_pulse;
    logic key_enable;
    logic panel_enable;
    logic ind_remote;
    logic ind_listen;
    logic ind_talk;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
  } rlm_state_t;
endpackage : rlm_pkg

/* design/rlm_ctrl.sv */
// remote/local/lockout state machine with axi4-lite registers
// assumes bus events (ren, listen, talk, srq) synchronous to aclk
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - remote: panel keys off except local/power/audio
// - local key disabled only by lockout command
// - remote listener accepts data, ren, gtl, sdc, trigger
// - listen/talk indicators follow addressing in both modes
// - remote entry restores last remote trigger config
// - local: all panels enabled, full settle repeat
// - talker may send data, status, srq, take control
// - dcl, lockout, clear-lockout, ifc act regardless
// - ren with listen moves local to remote
// - remote entry invalidates active measurements
// - repeat mode: new measurement cycle starts itself
// - single mode: wait for a trigger event
// - gtl while listening or ren low gives local
// - remote indicator off on leaving remote
// - local key returns local unless locked out
// - gtl keeps lockout for next remote entry
// - locked out: only ren false or gtl returns local
// - clear-lockout: local, lockout cleared, default trigger
// - power cycle returns local and power-up config
// - device clear empties queues, keeps settings
// - status byte bit 6 shows service request
module rlm_ctrl import rlm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ren,
  input wire logic listen_addr,
  input wire logic talk_addr,
  input wire logic local_key,
  input wire logic srq_in,
  output logic ind_remote,
  output logic ind_listen,
  output logic ind_talk,
  output logic panel_enable,
  output logic local_key_enable,
  output logic clear_pulse,
  output logic meas_valid,
  output logic srq_out
);
  rlm_state_t s;
  rlm_state_t next_s;
  logic wr_fire;
  logic [31:0] wd;
  logic gtl;
  logic dcl;
  logic llo;
  logic get;
  logic abort_cmd;
  logic ifc;
  logic enter_remote;
  logic to_local;

  function automatic logic is_remote(input rlm_mode_t m);
    is_remote = (m != RLM_LOCAL);
  endfunction : is_remote

  always_comb begin
    next_s = s;
    next_s.clear_pulse = 1'b0;
    // write channel capture
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
      next_s.awready = 1'b0;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      next_s.wready = 1'b0;
    end
    wr_fire = s.aw_got && s.w_got && !s.bvalid;
    wd = s.wdata;
    gtl = 1'b0;
    dcl = 1'b0;
    llo = 1'b0;
    get = 1'b0;
    abort_cmd = 1'b0;
    ifc = 1'b0;
    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (s.awaddr)
        OFF_CTRL: begin
          gtl = wd[CTL_GTL] && listen_addr;
          dcl = wd[CTL_DCL];
          llo = wd[CTL_LLO];
          get = wd[CTL_GET] && listen_addr;
          abort_cmd = wd[CTL_ABORT];
          ifc = wd[CTL_IFC];
        end
        OFF_TRIG: begin
          // trigger config accepted only as remote data
          if (is_remote(s.mode) && listen_addr) begin
            next_s.trig.complete_settle_option = wd[TR_SETTLE];
            next_s.trig.repeat_trigger_mode = wd[TR_REPEAT];
            next_s.remote_trig = next_s.trig;
            next_s.remote_trig_set = 1'b1;
          end
        end
        OFF_STATUS, OFF_SBYTE: ;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // read channel
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      case (s_axi_araddr)
        OFF_CTRL: ;
        OFF_STATUS: begin
          next_s.rdata[ST_REMOTE] = is_remote(s.mode);
          next_s.rdata[ST_LOCKOUT] = s.lockout;
          next_s.rdata[ST_LISTEN] = s.ind_listen;
          next_s.rdata[ST_TALK] = s.ind_talk;
          next_s.rdata[ST_MEAS_VALID] = s.meas_valid;
          next_s.rdata[ST_MEAS_BUSY] = s.meas_busy;
          next_s.rdata[ST_ARMED] = s.armed;
        end
        OFF_TRIG: begin
          next_s.rdata[TR_SETTLE] = s.trig.complete_settle_option;
          next_s.rdata[TR_REPEAT] = s.trig.repeat_trigger_mode;
        end
        OFF_SBYTE: next_s.rdata[7:0] = {s.sbyte[6], s.srq, s.sbyte[5:0]};
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    // status and service request, talker side
    next_s.srq = srq_in;
    next_s.sbyte = {1'b0, s.meas_valid, 5'h0};
    // mode machine
    enter_remote = 1'b0;
    to_local = 1'b0;
    if (llo) begin
      next_s.lockout = 1'b1;
    end
    case (s.mode)
      RLM_LOCAL: begin
        if (ren && listen_addr) begin
          enter_remote = 1'b1;
          next_s.mode = s.lockout || llo ? RLM_REMOTE_LLO : RLM_REMOTE;
        end
      end
      RLM_REMOTE: begin
        if (!ren || gtl || (local_key && !llo)) begin
          to_local = 1'b1;
        end else if (llo) begin
          next_s.mode = RLM_REMOTE_LLO;
        end
      end
      RLM_REMOTE_LLO: begin
        if (!ren) begin
          to_local = 1'b1;
        end else if (gtl) begin
          to_local = 1'b1;
        end
      end
      default: next_s.mode = RLM_LOCAL;
    endcase
    if (!ren) begin
      next_s.lockout = 1'b0;
    end
    if (to_local) begin
      next_s.mode = RLM_LOCAL;
      next_s.trig = TRIG_DEFAULT;
    end
    if (enter_remote) begin
      next_s.trig = s.remote_trig_set ? s.remote_trig : TRIG_DEFAULT;
      next_s.meas_valid = 1'b0;
      next_s.meas_busy = 1'b0;
      next_s.armed = 1'b1;
    end
    // measurement cycle sequencing
    if (!enter_remote) begin
      if (s.meas_busy) begin
        if (s.meas_cnt == 8'(MEAS_CYC - 1)) begin
          next_s.meas_busy = 1'b0;
          next_s.meas_valid = 1'b1;
        end else begin
          next_s.meas_cnt = s.meas_cnt + 8'h01;
        end
      end else if (s.armed || get) begin
        if (s.trig.repeat_trigger_mode || get) begin
          next_s.meas_busy = 1'b1;
          next_s.meas_cnt = 8'h00;
          next_s.armed = 1'b0;
        end
      end else if (s.trig.repeat_trigger_mode) begin
        next_s.armed = 1'b1;
      end
    end
    if (abort_cmd || ifc) begin
      next_s.meas_busy = 1'b0;
      next_s.armed = 1'b0;
    end
    if (dcl || ifc) begin
      next_s.clear_pulse = 1'b1;
      next_s.armed = 1'b0;
    end
    // panel and indicators
    next_s.panel_enable = !is_remote(next_s.mode);
    next_s.key_enable = (next_s.mode != RLM_REMOTE_LLO);
    next_s.ind_remote = is_remote(next_s.mode);
    next_s.ind_listen = listen_addr && !ifc;
    next_s.ind_talk = talk_addr && !ifc;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.mode <= RLM_LOCAL;
      s.trig <= TRIG_DEFAULT;
      s.panel_enable <= 1'b1;
      s.key_enable <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign ind_remote = s.ind_remote;
  assign ind_listen = s.ind_listen;
  assign ind_talk = s.ind_talk;
  assign panel_enable = s.panel_enable;
  assign local_key_enable = s.key_enable;
  assign clear_pulse = s.clear_pulse;
  assign meas_valid = s.meas_valid;
  assign srq_out = s.srq;

  sequence s_go_remote;
    s.mode == RLM_LOCAL && ren && listen_addr;
  endsequence

  property p_remote_entry;
    @(posedge aclk) disable iff (!aresetn)
      s_go_remote |=> is_remote(s.mode) && !s.meas_valid;
  endproperty
  a_remote_entry: assert property (p_remote_entry)
    else $error("remote entry missed or result kept");

  property p_ind_after;
    @(posedge aclk) disable iff (!aresetn)
      s_go_remote |=> ind_remote && !panel_enable;
  endproperty
  a_ind_after: assert property (p_ind_after)
    else $error("remote indicator not on after entry");

  property p_ren_low;
    @(posedge aclk) disable iff (!aresetn)
      is_remote(s.mode) && !ren |=> s.mode == RLM_LOCAL && !s.lockout
        && s.trig == TRIG_DEFAULT;
  endproperty
  a_ren_low: assert property (p_ren_low)
    else $error("ren low did not return local");

  property p_lockout_key;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == RLM_REMOTE_LLO && ren && local_key && !gtl
        |=> s.mode == RLM_REMOTE_LLO;
  endproperty
  a_lockout_key: assert property (p_lockout_key)
    else $error("local key left lockout");

  property p_key_local;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == RLM_REMOTE && ren && local_key && !llo
        |=> s.mode == RLM_LOCAL;
  endproperty
  a_key_local: assert property (p_key_local)
    else $error("local key ignored");

  property p_local_trig;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == RLM_LOCAL && $past(s.mode) == RLM_LOCAL
        |-> s.trig == TRIG_DEFAULT && s.panel_enable;
  endproperty
  a_local_trig: assert property (p_local_trig)
    else $error("local mode not default trigger");

  property p_indicators;
    @(posedge aclk) disable iff (!aresetn)
      ##1 ind_listen == $past(listen_addr && !ifc);
  endproperty
  a_indicators: assert property (p_indicators)
    else $error("listen indicator wrong");

  property p_keep_lockout;
    @(posedge aclk) disable iff (!aresetn)
      s.mode == RLM_REMOTE_LLO && ren && gtl
        |=> s.mode == RLM_LOCAL && s.lockout;
  endproperty
  a_keep_lockout: assert property (p_keep_lockout)
    else $error("go-to-local lost lockout");

  property p_single_wait;
    @(posedge aclk) disable iff (!aresetn)
      s.armed && !s.meas_busy && !s.trig.repeat_trigger_mode && !get
        && !enter_remote |=> !s.meas_busy;
  endproperty
  a_single_wait: assert property (p_single_wait)
    else $error("single mode started untriggered");

  property p_meas_done;
    @(posedge aclk) disable iff (!aresetn)
      $rose(s.meas_busy) |-> ##[1:30] !s.meas_busy;
  endproperty
  a_meas_done: assert property (p_meas_done)
    else $error("measurement never completed");
endmodule : rlm_ctrl

/* verification/rlm_ctlr_model.sv */
// bus-line side of the system controller facing the mode controller
// assumes the bench calls lines() from its own clocked sequence
`timescale 1ns/1ps
module rlm_ctlr_model (
  input wire logic aclk,
  output logic ren,
  output logic listen_addr,
  output logic talk_addr
);
  initial begin
    ren = 1'b0;
    listen_addr = 1'b0;
    talk_addr = 1'b0;
  end
  // ren plus listen is the remote message, ren low clears lockout
  task automatic lines(input logic r, input logic l, input logic t);
    @(posedge aclk);
    ren <= r;
    listen_addr <= l;
    talk_addr <= t;
  endtask : lines
endmodule : rlm_ctlr_model

/* verification/testbench.sv */
// self-checking bench for the remote/local mode controller
// assumes the axi4-lite map and timing of the register package
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h seen %h", nm, e, g); end end
module testbench import rlm_pkg::*;;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rlm_exp_t;
  logic aclk = 1'b0, aresetn = 1'b0, local_key = 1'b0, srq_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ren, listen_addr, talk_addr, ind_remote, ind_listen;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic ind_talk, panel_enable, local_key_enable, clear_pulse, meas_valid;
  logic srq_out;
  int errors = 0, compares = 0, clr_n = 0, c;
  integer seed = 32'h63A9C7C5;
  logic [31:0] r;
  rlm_exp_t q[$];
  rlm_exp_t e;
  always #25 aclk = ~aclk;
  rlm_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ren, .listen_addr, .talk_addr, .local_key,
    .srq_in, .ind_remote, .ind_listen, .ind_talk, .panel_enable,
    .local_key_enable, .clear_pulse, .meas_valid, .srq_out);
  rlm_ctlr_model ctl (.aclk, .ren, .listen_addr, .talk_addr);
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] er;
    er = (a > OFF_SBYTE) ? RESP_SLVERR : RESP_OKAY;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] rs);
    q.push_back('{d: d, m: m, r: rs});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic press();
    @(posedge aclk);
    local_key <= 1'b1;
    @(posedge aclk);
    local_key <= 1'b0;
    tick(3);
  endtask : press
  task automatic wait_meas(input logic v);
    int n;
    n = 0;
    while (meas_valid !== v && n < 80) begin
      @(posedge aclk);
      n++;
    end
    `CHK("meas_valid", v, meas_valid)
  endtask : wait_meas
  always @(posedge aclk) begin
    if (clear_pulse === 1'b1) clr_n++;
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      `CHK("rdata", e.d, s_axi_rdata & e.m)
      `CHK("rresp", e.r, s_axi_rresp)
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test();
  end
  initial begin
    tick(3);
    aresetn <= 1'b1;
    `CHK("key_en", 1'b1, local_key_enable)
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h10, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      ctl.lines(1'b0, r[0], r[1]);
      tick(3);
      `CHK("ind_listen", r[0], ind_listen)
      `CHK("ind_talk", r[1], ind_talk)
      `CHK("panel", 1'b1, panel_enable)
    end
    $display("test reset and addressing done");
    ctl.lines(1'b1, 1'b1, 1'b0);
    tick(3);
    `CHK("ind_remote", 1'b1, ind_remote)
    `CHK("panel", 1'b0, panel_enable)
    `CHK("key_en", 1'b1, local_key_enable)
    `CHK("meas_valid", 1'b0, meas_valid)
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    r = $random(seed);
    wr(OFF_TRIG, {30'h0, r[1:0]});
    rd(OFF_TRIG, {30'h0, r[1:0]}, 32'h3, RESP_OKAY);
    wr(OFF_TRIG, 32'h0);
    c = clr_n;
    wr(OFF_CTRL, 32'h1 << CTL_DCL);
    wr(OFF_CTRL, 32'h1 << CTL_ABORT);
    wr(OFF_CTRL, 32'h1 << CTL_IFC);
    tick(3);
    `CHK("clears", c + 2, clr_n)
    $display("test remote entry and clears done");
    ctl.lines(1'b1, 1'b0, 1'b0);
    press();
    `CHK("ind_remote", 1'b0, ind_remote)
    `CHK("panel", 1'b1, panel_enable)
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    ctl.lines(1'b1, 1'b1, 1'b0);
    tick(3);
    rd(OFF_TRIG, 32'h0, 32'h3, RESP_OKAY);
    tick(40);
    `CHK("meas_valid", 1'b0, meas_valid)
    wr(OFF_CTRL, 32'h1 << CTL_GET);
    wait_meas(1'b1);
    $display("test local key and single trigger done");
    wr(OFF_CTRL, 32'h1 << CTL_LLO);
    tick(3);
    `CHK("key_en", 1'b0, local_key_enable)
    rd(OFF_STATUS, 32'h7, 32'hF, RESP_OKAY);
    press();
    `CHK("ind_remote", 1'b1, ind_remote)
    fork
      wr(OFF_CTRL, 32'h1 << CTL_GTL);
      begin
        @(posedge aclk iff (s_axi_awvalid && s_axi_awready));
        ctl.lines(1'b1, 1'b0, 1'b0);
      end
    join
    tick(2);
    `CHK("ind_remote", 1'b0, ind_remote)
    `CHK("panel", 1'b1, panel_enable)
    rd(OFF_STATUS, 32'h2, 32'h3, RESP_OKAY);
    ctl.lines(1'b1, 1'b1, 1'b0);
    tick(3);
    `CHK("ind_remote", 1'b1, ind_remote)
    `CHK("key_en", 1'b0, local_key_enable)
    ctl.lines(1'b0, 1'b1, 1'b0);
    tick(3);
    `CHK("ind_remote", 1'b0, ind_remote)
    `CHK("key_en", 1'b1, local_key_enable)
    rd(OFF_STATUS, 32'h0, 32'h3, RESP_OKAY);
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    $display("test lockout done");
    ctl.lines(1'b1, 1'b1, 1'b1);
    tick(3);
    wr(OFF_TRIG, 32'h3);
    ctl.lines(1'b1, 1'b0, 1'b1);
    press();
    wait_meas(1'b1);
    ctl.lines(1'b1, 1'b1, 1'b1);
    tick(2);
    `CHK("meas_valid", 1'b0, meas_valid)
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    wait_meas(1'b1);
    srq_in <= 1'b1;
    tick(3);
    `CHK("srq_out", 1'b1, srq_out)
    rd(OFF_SBYTE, 32'h40, 32'h40, RESP_OKAY);
    aresetn <= 1'b0;
    ctl.lines(1'b0, 1'b0, 1'b0);
    tick(2);
    aresetn <= 1'b1;
    tick(3);
    `CHK("ind_remote", 1'b0, ind_remote)
    rd(OFF_STATUS, 32'h0, 32'h3, RESP_OKAY);
    rd(OFF_TRIG, 32'h3, 32'h3, RESP_OKAY);
    $display("test repeat measurement and reset done");
    tick(2);
    stop_test();
  end
endmodule : testbench
